// ### rtl/hdsf_formatter.sv
`timescale 1ns/1ps
`include "hdsf_params.svh"

module hdsf_formatter (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // Parallel word pair from the video source
  input wire logic [`HDSF_WORD_W-1:0] Y_WORD,
  input wire logic [`HDSF_WORD_W-1:0] C_WORD,
  input wire logic ACTIVE,
  input wire logic BLANK,
  input wire logic EAV_END,
  input wire logic [`HDSF_LINE_W-1:0] LINE_NUM,
  // Pacing and observation
  output logic WORD_REQ,
  output logic [`HDSF_WORD_W-1:0] MUX_WORD,
  // Serial link
  output logic SER_OUT
);

  logic [3:0] bit_cnt_r;
  logic half_r;
  logic load;
  logic capture;
  hdsf_pkg::hdsf_pos_type pos_r;
  hdsf_pkg::hdsf_pos_type pos_nxt;
  logic eav_pend_r;
  logic [`HDSF_LINE_W-1:0] line_r;
  logic [`HDSF_WORD_W-1:0] y_raw_r;
  logic y_blank_r;
  logic cov_y_r;
  logic cov_c_r;
  logic cov_nxt;
  logic [`HDSF_WORD_W-1:0] c_fmt;
  logic [`HDSF_WORD_W-1:0] y_fmt;
  logic [`HDSF_WORD_W-1:0] sh_r;
  logic [`HDSF_CRC_W-1:0] crc_y;
  logic [`HDSF_CRC_W-1:0] crc_c;
  logic crc_clr;
  logic [`HDSF_SCR_W-1:0] scr_r;
  logic scr_bit;
  logic req_r;
  logic ser_r;
  logic [`HDSF_WORD_W-1:0] mux_r;

  function automatic logic [`HDSF_WORD_W-1:0] ln_lo(input logic [`HDSF_LINE_W-1:0] ln);
    ln_lo = {~ln[6], ln[6:0], 2'h0};
  endfunction

  function automatic logic [`HDSF_WORD_W-1:0] ln_hi(input logic [`HDSF_LINE_W-1:0] ln);
    ln_hi = {1'b1, 3'h0, ln[10:7], 2'h0};
  endfunction

  function automatic logic [`HDSF_WORD_W-1:0] ck_lo(input logic [`HDSF_CRC_W-1:0] c);
    ck_lo = {~c[8], c[8:0]};
  endfunction

  function automatic logic [`HDSF_WORD_W-1:0] ck_hi(input logic [`HDSF_CRC_W-1:0] c);
    ck_hi = {~c[17], c[17:9]};
  endfunction

  // A word goes out every ten clocks, so a stream pair every twenty
  assign load = (bit_cnt_r == `HDSF_BIT_LAST);
  assign capture = load && half_r;

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      bit_cnt_r <= 4'h0;
      half_r <= 1'b1;
    end
    else if (load)
    begin
      bit_cnt_r <= 4'h0;
      half_r <= ~half_r;
    end
    else
      bit_cnt_r <= bit_cnt_r + 4'h1;
  end

  // Request is high in the cycle whose closing edge takes the pair
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      req_r <= 1'b0;
    else
      req_r <= half_r && (bit_cnt_r == 4'h8);
  end

  // Insertion sequence after the end code
  always_comb
  begin
    case (pos_r)
      hdsf_pkg::HDSF_POS_NORM: pos_nxt = eav_pend_r ? hdsf_pkg::HDSF_POS_LN0
                                                    : hdsf_pkg::HDSF_POS_NORM;
      hdsf_pkg::HDSF_POS_LN0: pos_nxt = hdsf_pkg::HDSF_POS_LN1;
      hdsf_pkg::HDSF_POS_LN1: pos_nxt = hdsf_pkg::HDSF_POS_CK0;
      hdsf_pkg::HDSF_POS_CK0: pos_nxt = hdsf_pkg::HDSF_POS_CK1;
      hdsf_pkg::HDSF_POS_CK1: pos_nxt = hdsf_pkg::HDSF_POS_NORM;
      default: pos_nxt = hdsf_pkg::HDSF_POS_NORM;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      pos_r <= hdsf_pkg::HDSF_POS_NORM;
      eav_pend_r <= 1'b0;
    end
    else if (capture)
    begin
      pos_r <= pos_nxt;
      eav_pend_r <= (pos_nxt == hdsf_pkg::HDSF_POS_NORM) && EAV_END;
    end
  end

  // Line number is taken with the last end-code pair
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      line_r <= {`HDSF_LINE_W{1'b0}};
    else if (capture && EAV_END && (pos_nxt == hdsf_pkg::HDSF_POS_NORM))
      line_r <= LINE_NUM;
  end

  // Words flagged ACTIVE (the end code only when flagged) and line number words are covered; nothing else
  always_comb
  begin
    case (pos_nxt)
      hdsf_pkg::HDSF_POS_NORM: cov_nxt = ACTIVE;
      hdsf_pkg::HDSF_POS_LN0: cov_nxt = 1'b1;
      hdsf_pkg::HDSF_POS_LN1: cov_nxt = 1'b1;
      default: cov_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      y_raw_r <= {`HDSF_WORD_W{1'b0}};
      y_blank_r <= 1'b0;
      cov_y_r <= 1'b0;
      cov_c_r <= 1'b0;
    end
    else if (capture)
    begin
      y_raw_r <= Y_WORD;
      y_blank_r <= BLANK;
      cov_y_r <= cov_nxt;
      cov_c_r <= cov_nxt;
    end
  end

  // Chroma word is formatted from the inputs on the capture edge
  always_comb
  begin
    case (pos_nxt)
      hdsf_pkg::HDSF_POS_LN0: c_fmt = ln_lo(line_r);
      hdsf_pkg::HDSF_POS_LN1: c_fmt = ln_hi(line_r);
      hdsf_pkg::HDSF_POS_CK0: c_fmt = ck_lo(crc_c);
      hdsf_pkg::HDSF_POS_CK1: c_fmt = ck_hi(crc_c);
      default: c_fmt = BLANK ? `HDSF_C_BLANK : C_WORD;
    endcase
  end

  // Luma word is formatted ten clocks later, after its last check bit
  always_comb
  begin
    case (pos_r)
      hdsf_pkg::HDSF_POS_LN0: y_fmt = ln_lo(line_r);
      hdsf_pkg::HDSF_POS_LN1: y_fmt = ln_hi(line_r);
      hdsf_pkg::HDSF_POS_CK0: y_fmt = ck_lo(crc_y);
      hdsf_pkg::HDSF_POS_CK1: y_fmt = ck_hi(crc_y);
      default: y_fmt = y_blank_r ? `HDSF_Y_BLANK : y_raw_r;
    endcase
  end

  // Word multiplexer and serializer
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      sh_r <= {`HDSF_WORD_W{1'b0}};
      mux_r <= {`HDSF_WORD_W{1'b0}};
    end
    else if (load)
    begin
      sh_r <= half_r ? c_fmt : y_fmt;
      mux_r <= half_r ? c_fmt : y_fmt;
    end
    else
      sh_r <= {1'b0, sh_r[`HDSF_WORD_W-1:1]};
  end

  // Clearing after the second check pair leaves zero for the next line
  assign crc_clr = capture && (pos_r == hdsf_pkg::HDSF_POS_CK1);

  hdsf_line_check u_check_y (
    .clk(CLK),
    .rst_b(RST_B),
    .clr(crc_clr),
    .en(half_r && cov_y_r),
    .bit_in(sh_r[0]),
    .crc(crc_y)
  );

  hdsf_line_check u_check_c (
    .clk(CLK),
    .rst_b(RST_B),
    .clr(crc_clr),
    .en(!half_r && cov_c_r),
    .bit_in(sh_r[0]),
    .crc(crc_c)
  );

  // Scrambler works on the serial bit; history holds scrambled bits
  assign scr_bit = sh_r[0] ^ scr_r[`HDSF_SCR_TAP_A] ^ scr_r[`HDSF_SCR_TAP_B];

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      scr_r <= {`HDSF_SCR_W{1'b0}};
      ser_r <= 1'b0;
    end
    else
    begin
      scr_r <= {scr_r[`HDSF_SCR_W-2:0], scr_bit};
      ser_r <= ser_r ^ scr_bit;
    end
  end

  assign WORD_REQ = req_r;
  assign MUX_WORD = mux_r;
  assign SER_OUT = ser_r;

endmodule

// ### rtl/hdsf_params.svh
`ifndef HDSF_PARAMS_SVH
`define HDSF_PARAMS_SVH

// Word and serial framing
`define HDSF_WORD_W 10
`define HDSF_LINE_W 11
`define HDSF_BIT_LAST 4'h9
`define HDSF_CLK_HZ 20000000

// Blanking fill levels (16.00 and 128.00 in 10-bit code)
`define HDSF_Y_BLANK 10'h040
`define HDSF_C_BLANK 10'h200

// Line check: x^18 + x^5 + x^4 + 1, reflected feedback taps
`define HDSF_CRC_W 18
`define HDSF_CRC_TAPS 18'h03000
`define HDSF_CRC_INIT 18'h00000

// Scrambler x^9 + x^4 + 1: taps on the 9th and 4th past bits
`define HDSF_SCR_W 9
`define HDSF_SCR_TAP_A 8
`define HDSF_SCR_TAP_B 3

`endif

// ### rtl/hdsf_pkg.sv
package hdsf_pkg;

  // Position of the word pair after the end code; Gray along the path except the CK1 to NORM return
  typedef enum logic [2:0] {
    HDSF_POS_NORM = 3'h0,
    HDSF_POS_LN0 = 3'h1,
    HDSF_POS_LN1 = 3'h3,
    HDSF_POS_CK0 = 3'h2,
    HDSF_POS_CK1 = 3'h6
  } hdsf_pos_type;

endpackage

// ### rtl/hdsf_line_check.sv
`timescale 1ns/1ps
`include "hdsf_params.svh"

module hdsf_line_check (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Control
  input wire logic clr,
  input wire logic en,
  input wire logic bit_in,
  // Result
  output logic [`HDSF_CRC_W-1:0] crc
);

  logic fb;
  logic [`HDSF_CRC_W-1:0] crc_nxt;

  always_comb
  begin
    fb = bit_in ^ crc[0];
    crc_nxt = {fb, crc[`HDSF_CRC_W-1:1]} ^ (fb ? `HDSF_CRC_TAPS : `HDSF_CRC_INIT);
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      crc <= `HDSF_CRC_INIT;
    else if (clr)
      crc <= `HDSF_CRC_INIT;
    else if (en)
      crc <= crc_nxt;
  end

endmodule

// ### sim/hdsf_rx_model.sv
`timescale 1ns/1ps
module hdsf_rx_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Serial line and recovered word
  input wire logic ser,
  output logic [9:0] word
);
  logic prev_r;
  logic [8:0] hist_r;
  logic s;
  // Undo the line inversion coding first
  assign s = ser ^ prev_r;
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      prev_r <= 1'b0;
      hist_r <= 9'h000;
      word <= 10'h000;
    end
    else
    begin
      prev_r <= ser;
      hist_r <= {hist_r[7:0], s};
      word <= {s ^ hist_r[8] ^ hist_r[3], word[9:1]};
    end
endmodule

// ### sim/hdsf_formatter_asserts.sv
`timescale 1ns/1ps
module hdsf_formatter_chk (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // Source pair
  input wire logic [9:0] Y_WORD,
  input wire logic [9:0] C_WORD,
  input wire logic ACTIVE,
  input wire logic BLANK,
  input wire logic EAV_END,
  input wire logic [10:0] LINE_NUM,
  // Outputs
  input wire logic WORD_REQ,
  input wire logic [9:0] MUX_WORD,
  input wire logic SER_OUT
);
  logic [2:0] pos_r;
  logic [10:0] ln_r;
  // Tracks the four inserted pairs after the end code
  always_ff @(posedge CLK or negedge RST_B)
    if (!RST_B)
    begin
      pos_r <= 3'h0;
      ln_r <= 11'h000;
    end
    else if (WORD_REQ)
    begin
      if (pos_r != 3'h0)
        pos_r <= (pos_r == 3'h4) ? 3'h0 : pos_r + 3'h1;
      else if (EAV_END)
      begin
        pos_r <= 3'h1;
        ln_r <= LINE_NUM;
      end
    end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  a_req_period: assert property (WORD_REQ |-> ##20 WORD_REQ)
    else $error("pair pacing");
  a_req_gap: assert property (WORD_REQ |=> !WORD_REQ [*8])
    else $error("request gap");
  a_mux_hold: assert property ($changed(MUX_WORD) |-> $past(WORD_REQ) || $past(WORD_REQ, 11))
    else $error("word change off slot");
  a_blank_c: assert property (WORD_REQ && BLANK && pos_r == 3'h0 |=> MUX_WORD == 10'h200)
    else $error("chroma fill");
  a_blank_y: assert property (WORD_REQ && BLANK && pos_r == 3'h0 |-> ##11 MUX_WORD == 10'h040)
    else $error("luma fill");
  a_pass_c: assert property (WORD_REQ && !BLANK && pos_r == 3'h0 |=> MUX_WORD == $past(C_WORD))
    else $error("chroma pass");
  a_ln_lo: assert property (WORD_REQ && pos_r == 3'h1 |=>
    MUX_WORD == {~ln_r[6], ln_r[6:0], 2'h0})
    else $error("line word lo");
  a_ln_hi: assert property (WORD_REQ && pos_r == 3'h2 |-> ##11
    MUX_WORD == {1'b1, 3'h0, ln_r[10:7], 2'h0})
    else $error("line word hi");
  a_ck_inv: assert property (WORD_REQ && pos_r > 3'h2 |=> MUX_WORD[9] != MUX_WORD[8])
    else $error("check word bit9");
  c_eav: cover property (WORD_REQ && EAV_END);
  c_blank: cover property (WORD_REQ && BLANK);
  c_ck1: cover property (WORD_REQ && pos_r == 3'h4);
endmodule
bind hdsf_formatter hdsf_formatter_chk u_chk (.CLK(CLK), .RST_B(RST_B), .Y_WORD(Y_WORD),
  .C_WORD(C_WORD), .ACTIVE(ACTIVE), .BLANK(BLANK), .EAV_END(EAV_END), .LINE_NUM(LINE_NUM),
  .WORD_REQ(WORD_REQ), .MUX_WORD(MUX_WORD), .SER_OUT(SER_OUT));

// ### sim/tb.sv
`timescale 1ns/1ps
`include "hdsf_params.svh"
module tb;
  logic CLK = 1'b0;
  logic RST_B = 1'b0;
  logic [9:0] Y_WORD = 10'h000;
  logic [9:0] C_WORD = 10'h000;
  logic ACTIVE = 1'b0;
  logic BLANK = 1'b0;
  logic EAV_END = 1'b0;
  logic [10:0] LINE_NUM = 11'h000;
  logic WORD_REQ;
  logic [9:0] MUX_WORD;
  logic SER_OUT;
  logic [9:0] rx;
  logic [9:0] py;
  logic first = 1'b1;
  int mismatches = 0;
  int tests_run = 0;
  int n;
  // Rows: luma, chroma, {active, blank, end}, expected luma, expected chroma
  logic [42:0] rows [5] = '{{10'h123, 10'h2a5, 3'h0, 10'h123, 10'h2a5},
    {10'h155, 10'h155, 3'h2, 10'h040, 10'h200}, {10'h3c1, 10'h00f, 3'h4, 10'h3c1, 10'h00f},
    {10'h2b4, 10'h1e7, 3'h4, 10'h2b4, 10'h1e7}, {10'h274, 10'h274, 3'h5, 10'h274, 10'h274}};
  hdsf_formatter u_dut (.CLK(CLK), .RST_B(RST_B), .Y_WORD(Y_WORD), .C_WORD(C_WORD),
    .ACTIVE(ACTIVE), .BLANK(BLANK), .EAV_END(EAV_END), .LINE_NUM(LINE_NUM),
    .WORD_REQ(WORD_REQ), .MUX_WORD(MUX_WORD), .SER_OUT(SER_OUT));
  hdsf_rx_model u_rx (.clk(CLK), .rst_b(RST_B), .ser(SER_OUT), .word(rx));
  always #25 CLK = ~CLK;
  task chk(input string nm, input logic [17:0] seen, input logic [17:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task end_of_test;
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  function automatic logic [17:0] crc(logic [17:0] c, logic [9:0] w);
    logic fb;
    for (int b = 0; b < 10; b++)
    begin
      fb = w[b] ^ c[0];
      c = {fb, c[17:1]} ^ (fb ? `HDSF_CRC_TAPS : 18'h00000);
    end
    return c;
  endfunction
  task wait_req(output int k);
    k = 0;
    do
    begin
      @(posedge CLK);
      #1 k++;
    end while (WORD_REQ !== 1'b1 && k < 40);
    if (k >= 40)
    begin
      mismatches++;
      end_of_test;
    end
  endtask
  task run_line(input logic [10:0] ln);
    logic [17:0] cy;
    logic [17:0] cc;
    logic [9:0] ey;
    logic [9:0] ec;
    cy = 18'h00000;
    cc = 18'h00000;
    LINE_NUM = ln;
    for (int i = 0; i < 9; i++)
    begin
      wait_req(n);
      if (i < 5)
        {Y_WORD, C_WORD, ACTIVE, BLANK, EAV_END, ey, ec} = rows[i];
      else
        {Y_WORD, C_WORD, ACTIVE, BLANK, EAV_END} = 23'h7fffff;
      case (i)
        5: ey = {~ln[6], ln[6:0], 2'h0};
        6: ey = {1'b1, 3'h0, ln[10:7], 2'h0};
        7: {ey, ec} = {~cy[8], cy[8:0], ~cc[8], cc[8:0]};
        8: {ey, ec} = {~cy[17], cy[17:9], ~cc[17], cc[17:9]};
        default: ;
      endcase
      if (i == 5 || i == 6)
        ec = ey;
      if (i < 5 ? ACTIVE : i < 7)
      begin
        cy = crc(cy, ey);
        cc = crc(cc, ec);
      end
      @(posedge CLK);
      #1 chk("mux_c", MUX_WORD, ec);
      @(posedge CLK);
      #1 if (!first) chk("rx_y", rx, py);
      repeat (9) @(posedge CLK);
      #1 chk("mux_y", MUX_WORD, ey);
      @(posedge CLK);
      #1 chk("rx_c", rx, ec);
      py = ey;
      first = 1'b0;
    end
  endtask
  initial
  begin
    repeat (12) @(posedge CLK);
    #1 RST_B = 1'b1;
    run_line(11'h4a5);
    run_line(11'h7ff);
    RST_B = 1'b0;
    #1 chk("reset_out", {WORD_REQ, MUX_WORD, SER_OUT}, 18'h00000);
    @(posedge CLK);
    #1 RST_B = 1'b1;
    first = 1'b1;
    wait_req(n);
    chk("first_req", n, 18'h00009);
    end_of_test;
  end
endmodule
